/* rtl/timer2_flags_map.svh */
// Purpose: offsets, field positions, reset values for timer2 flag block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef TIMER2_FLAGS_MAP_SVH
`define TIMER2_FLAGS_MAP_SVH
// ***************************************************************
// register byte offsets
// ***************************************************************
`define T2F_CTRL_OFF 12'h000
`define T2F_IRQ_STAT_OFF 12'h004
`define T2F_IRQ_MASK_OFF 12'h008
`define T2F_CFG_OFF 12'h00C
// ***************************************************************
// control register field positions
// ***************************************************************
`define T2F_OVF_BIT 7
`define T2F_EXT_BIT 6
`define T2F_RXSEL_BIT 5
`define T2F_TXSEL_BIT 4
`define T2F_EXTEN_BIT 3
// ***************************************************************
// reset values
// ***************************************************************
`define T2F_CTRL_RST 8'h00
`define T2F_MASK_RST 2'h0
`define T2F_CFG_RST 1'h0
`endif

/* rtl/timer2_flags_pkg.sv */
// Purpose: shared types for the timer2 flag block
// Assumes: nothing
// Notes: apb phase enum
package timer2_flags_pkg;
   // apb slave phase
   typedef enum logic [0:0] {APB_IDLE, APB_DONE} apb_phase_t;
   // baud source select
   typedef enum logic {SRC_TIMER1 = 1'b0, SRC_TIMER2 = 1'b1} baud_src_t;
endpackage

/* rtl/pin_sync3.sv */
// Purpose: three-flop synchroniser with agreement-qualified edge
// Assumes: pin asynchronous to pclk
// Notes: first flop read only by the second
`timescale 1ns/10ps
module pin_sync3 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic level,
   output logic fall
);
   // ***************************************************************
   // synchroniser chain
   // ***************************************************************
   logic s1_reg; // metastable stage
   logic s2_reg; // second stage
   logic s3_reg; // third stage
   // idle high so reset does not fake a falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // agreed level: changes once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b1;
      end else if (s2_reg == s3_reg) begin
         level <= s3_reg;
      end
   end
   // falling edge of the agreed level, one cycle pulse
   assign fall = level && (s2_reg == s3_reg) && !s3_reg;
endmodule

/* rtl/baud_mux.sv */
// Purpose: pick timer 1 or timer 2 overflow as a serial baud tick
// Assumes: overflow inputs are one-cycle pulses on pclk
// Notes: used once for receive, once for transmit
`timescale 1ns/10ps
module baud_mux
   import timer2_flags_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sel,
   input wire logic t1_ovf,
   input wire logic t2_ovf,
   output logic tick
);
   // registered tick so the serial port sees a clean flop output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 1'b0;
      end else begin
         tick <= (baud_src_t'(sel) == SRC_TIMER2) ? t2_ovf : t1_ovf;
      end
   end
endmodule

/* rtl/timer2_flags_baud_select.sv */
// Purpose: upper control bits of timer 2: flags, irq, baud select
// Assumes: counter, run control and capture logic live elsewhere
// Notes: apb slave, zero wait states, unmapped reads return zero
`timescale 1ns/10ps
`include "timer2_flags_map.svh"
module timer2_flags_baud_select
   import timer2_flags_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic t1_overflow,
   input wire logic t2_overflow,
   input wire logic ext_trigger_pin,
   input wire logic serial_mode13,
   output logic capture_reload,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   output logic t2_irq_req,
   output logic irq
);
   // ***************************************************************
   // apb decode
   // ***************************************************************
   logic setup; // setup phase seen
   logic wr_acc; // write in access phase
   logic rd_acc; // read in access phase
   logic hit_ctrl; // control register selected
   logic hit_stat; // status register selected
   logic hit_mask; // mask register selected
   logic hit_cfg; // config register selected
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign hit_ctrl = (paddr == `T2F_CTRL_OFF);
   assign hit_stat = (paddr == `T2F_IRQ_STAT_OFF);
   assign hit_mask = (paddr == `T2F_IRQ_MASK_OFF);
   assign hit_cfg = (paddr == `T2F_CFG_OFF);
   // zero wait state: answer in the first access cycle
   assign pready = 1'b1;
   // unmapped address completes with an error, no side effects
   assign pslverr = psel && penable &&
                    !(hit_ctrl || hit_stat || hit_mask || hit_cfg);

   // ***************************************************************
   // control register fields
   // ***************************************************************
   logic ovf_flag_reg; // second_timer_overflow_flag
   logic ext_flag_reg; // ext_trigger_flag
   logic rx_sel_reg; // receive baud select
   logic tx_sel_reg; // tx_baud_select
   logic ext_en_reg; // ext_trigger_enable
   logic [2:0] low_bits_reg; // run/mode bits held for the rest of timer
   logic t2_irq_en_reg; // timer 2 interrupt enable
   logic baud_use; // timer 2 is clocking the serial port
   logic trig_fall; // qualified falling edge from the pin
   logic ovf_set; // overflow flag set event
   logic ext_set; // trigger flag set event
   logic ctrl_wr; // software write to control

   assign ctrl_wr = wr_acc && hit_ctrl;
   assign baud_use = rx_sel_reg || tx_sel_reg;

   // the pin is outside pclk domain: three flops before use
   pin_sync3 u_trig_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_trigger_pin),
      .level(),
      .fall(trig_fall)
   );

   // capture/reload only while timer 2 is not the baud source
   assign ext_set = trig_fall && ext_en_reg && !baud_use;
   // overflow suppressed while timer 2 feeds the serial port
   assign ovf_set = t2_overflow && !baud_use;

   // capture or reload strobe to the counter logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_reload <= 1'b0;
      end else begin
         capture_reload <= ext_set;
      end
   end

   // overflow flag: set beats a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_flag_reg <= 1'b0;
      end else if (ovf_set) begin
         ovf_flag_reg <= 1'b1;
      end else if (ctrl_wr) begin
         ovf_flag_reg <= pwdata[`T2F_OVF_BIT];
      end
   end

   // trigger flag: hardware only sets, a software write loads the written bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_flag_reg <= 1'b0;
      end else if (ext_set) begin
         ext_flag_reg <= 1'b1;
      end else if (ctrl_wr) begin
         ext_flag_reg <= pwdata[`T2F_EXT_BIT];
      end
   end

   // plain software bits of the control byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_sel_reg <= 1'b0;
         tx_sel_reg <= 1'b0;
         ext_en_reg <= 1'b0;
         low_bits_reg <= 3'h0;
      end else if (ctrl_wr) begin
         rx_sel_reg <= pwdata[`T2F_RXSEL_BIT];
         tx_sel_reg <= pwdata[`T2F_TXSEL_BIT];
         ext_en_reg <= pwdata[`T2F_EXTEN_BIT];
         low_bits_reg <= pwdata[2:0];
      end
   end

   // timer 2 interrupt enable lives in the config register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t2_irq_en_reg <= `T2F_CFG_RST;
      end else if (wr_acc && hit_cfg) begin
         t2_irq_en_reg <= pwdata[0];
      end
   end

   // cpu vector request; the overflow flag requests it as well
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t2_irq_req <= 1'b0;
      end else begin
         t2_irq_req <= t2_irq_en_reg && (ext_flag_reg || ovf_flag_reg);
      end
   end

   // ***************************************************************
   // baud clock selection
   // ***************************************************************
   logic rx_tick; // raw receive tick
   logic tx_tick; // raw transmit tick

   baud_mux u_rx_mux (
      .pclk(pclk),
      .presetn(presetn),
      .sel(rx_sel_reg),
      .t1_ovf(t1_overflow),
      .t2_ovf(t2_overflow),
      .tick(rx_tick)
   );

   baud_mux u_tx_mux (
      .pclk(pclk),
      .presetn(presetn),
      .sel(tx_sel_reg),
      .t1_ovf(t1_overflow),
      .t2_ovf(t2_overflow),
      .tick(tx_tick)
   );

   // only modes 1 and 3 take their clock from the timers
   assign rx_baud_tick = rx_tick && serial_mode13;
   assign tx_baud_tick = tx_tick && serial_mode13;

   // ***************************************************************
   // interrupt status, mask, line
   // ***************************************************************
   logic [1:0] stat_reg; // bit1 overflow event, bit0 trigger event
   logic [1:0] mask_reg; // 1 lets the event onto irq
   logic stat_rd; // status read completes
   logic [1:0] stat_next; // status after this cycle's events and read

   assign stat_rd = rd_acc && hit_stat;
   // a read clears only the bits it reported in prdata, so an event
   // that lands on the setup edge is kept for the next read
   assign stat_next = (stat_rd ? (stat_reg & ~prdata[1:0]) : stat_reg) |
                      {ovf_set, ext_set};

   // sticky events; a set in the read cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= 2'h0;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= `T2F_MASK_RST;
      end else if (wr_acc && hit_mask) begin
         mask_reg <= pwdata[1:0];
      end
   end

   // level interrupt from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(stat_next & mask_reg);
      end
   end

   // ***************************************************************
   // read data, registered at the setup phase
   // ***************************************************************
   logic [7:0] ctrl_view; // control byte as software sees it
   assign ctrl_view = {ovf_flag_reg, ext_flag_reg, rx_sel_reg, tx_sel_reg,
                       ext_en_reg, low_bits_reg};

   // loaded in setup so data stand valid through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         case (1'b1)
            hit_ctrl: prdata <= {24'h000000, ctrl_view};
            hit_stat: prdata <= {30'h00000000, stat_reg};
            hit_mask: prdata <= {30'h00000000, mask_reg};
            hit_cfg: prdata <= {31'h00000000, t2_irq_en_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   // a timer 2 overflow outside baud use always lands in the flag
   property p_ovf_set;
      @(posedge pclk) disable iff (!presetn)
      ovf_set |=> ovf_flag_reg;
   endproperty
   a_ovf_set: assert property (p_ovf_set)
      else $error("overflow flag not set");

   // only a software write may take the overflow flag down
   property p_ovf_hold;
      @(posedge pclk) disable iff (!presetn)
      (ovf_flag_reg && !ctrl_wr) |=> ovf_flag_reg;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("overflow flag cleared by hardware");

   // no overflow flag while timer 2 feeds the serial port
   property p_ovf_block;
      @(posedge pclk) disable iff (!presetn)
      (baud_use && !ctrl_wr && !ovf_flag_reg) |=> !ovf_flag_reg;
   endproperty
   a_ovf_block: assert property (p_ovf_block)
      else $error("overflow flag set during baud use");

   // an enabled trigger edge sets the trigger flag
   property p_ext_set;
      @(posedge pclk) disable iff (!presetn)
      (trig_fall && ext_en_reg && !baud_use) |=> ext_flag_reg;
   endproperty
   a_ext_set: assert property (p_ext_set)
      else $error("trigger flag not set");

   // only a software write may take the trigger flag down
   property p_ext_hold;
      @(posedge pclk) disable iff (!presetn)
      (ext_flag_reg && !ctrl_wr) |=> ext_flag_reg;
   endproperty
   a_ext_hold: assert property (p_ext_hold)
      else $error("trigger flag cleared by hardware");

   // enabled trigger flag raises the cpu request
   property p_irq_req;
      @(posedge pclk) disable iff (!presetn)
      (ext_flag_reg && t2_irq_en_reg) |=> t2_irq_req;
   endproperty
   a_irq_req: assert property (p_irq_req)
      else $error("timer 2 request missing");

   // receive select 0 passes timer 1 overflows
   property p_rx_t1;
      @(posedge pclk) disable iff (!presetn)
      (!rx_sel_reg && t1_overflow && !t2_overflow) |=> rx_tick;
   endproperty
   a_rx_t1: assert property (p_rx_t1)
      else $error("receive tick not from timer 1");

   // receive select 1 ignores timer 1 overflows
   property p_rx_t2;
      @(posedge pclk) disable iff (!presetn)
      (rx_sel_reg && !t2_overflow) |=> !rx_tick;
   endproperty
   a_rx_t2: assert property (p_rx_t2)
      else $error("receive tick not from timer 2");

   // transmit tick follows the selected source one cycle later
   property p_tx_sel;
      @(posedge pclk) disable iff (!presetn)
      1'b1 |=> tx_tick == $past(tx_sel_reg ? t2_overflow : t1_overflow);
   endproperty
   a_tx_sel: assert property (p_tx_sel)
      else $error("transmit tick wrong source");

   // no capture while disabled or while timer 2 clocks the serial port
   property p_no_cap;
      @(posedge pclk) disable iff (!presetn)
      (!ext_en_reg || baud_use) |=> !capture_reload;
   endproperty
   a_no_cap: assert property (p_no_cap)
      else $error("capture while disabled or baud use");

   // an overflow event stays until a status read has reported it
   property p_stat_keep1;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[1] && !(stat_rd && prdata[1])) |=> stat_reg[1];
   endproperty
   a_stat_keep1: assert property (p_stat_keep1)
      else $error("overflow event lost unread");

   // a trigger event stays until a status read has reported it
   property p_stat_keep0;
      @(posedge pclk) disable iff (!presetn)
      (stat_reg[0] && !(stat_rd && prdata[0])) |=> stat_reg[0];
   endproperty
   a_stat_keep0: assert property (p_stat_keep0)
      else $error("trigger event lost unread");

   c_ext: cover property (@(posedge pclk) disable iff (!presetn) ext_set);
   c_ovf: cover property (@(posedge pclk) disable iff (!presetn) ovf_set);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

/* dv/test_timer2_flags_baud_select.sv */
// Purpose: self-checking bench for the timer 2 flag and baud select block
// Assumes: zero wait state apb slave, map and bit layout from the map header
// Notes: a set mask bit lets its status bit onto irq
`timescale 1ns/10ps
`include "timer2_flags_map.svh"
module test_timer2_flags_baud_select;
   import timer2_flags_pkg::*;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic pclk = 1'b0; // 200 mhz system clock
   logic presetn = 1'b0; // active low reset
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic t1_overflow = 1'b0; // timer 1 overflow pulse
   logic t2_overflow = 1'b0; // timer 2 overflow pulse
   logic ext_trigger_pin = 1'b1; // idles high, falling edge is the event
   logic serial_mode13 = 1'b1; // serial port in a timer-clocked mode
   logic capture_reload;
   logic rx_baud_tick;
   logic tx_baud_tick;
   logic t2_irq_req;
   logic irq;
   int mismatches = 0;
   int check_count = 0;
   int rx_cnt = 0; // running pulse counts, compared as deltas
   int tx_cnt = 0;
   int cap_cnt = 0;
   int r0, t0, c0;
   logic [1:0] sel; // {rx select, tx select}
   logic last_err; // pslverr taken with the last transfer
   // ***************************************************************
   // clock, design, pulse counters
   // ***************************************************************
   always #2.5 pclk = ~pclk;
   timer2_flags_baud_select uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .t1_overflow(t1_overflow),
      .t2_overflow(t2_overflow), .ext_trigger_pin(ext_trigger_pin),
      .serial_mode13(serial_mode13), .capture_reload(capture_reload),
      .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
      .t2_irq_req(t2_irq_req), .irq(irq));
   // counting pulses avoids depending on the exact tick latency
   always @(posedge pclk) begin
      rx_cnt <= rx_cnt + int'(rx_baud_tick === 1'b1);
      tx_cnt <= tx_cnt + int'(tx_baud_tick === 1'b1);
      cap_cnt <= cap_cnt + int'(capture_reload === 1'b1);
   end
   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      apb(1'b1, a, d, dummy);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      apb(1'b0, a, 32'h0000_0000, v);
      check(v, exp);
   endtask
   // one-cycle overflow pulse from timer 1 (0) or timer 2 (1)
   task automatic ovf_pulse(input logic t2);
      @(posedge pclk);
      if (t2) begin
         t2_overflow <= 1'b1;
      end else begin
         t1_overflow <= 1'b1;
      end
      @(posedge pclk);
      t1_overflow <= 1'b0;
      t2_overflow <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   // falling then rising edge, long enough to pass the synchroniser
   task automatic trig_edge;
      @(posedge pclk);
      ext_trigger_pin <= 1'b0;
      repeat (10) @(posedge pclk);
      ext_trigger_pin <= 1'b1;
      repeat (10) @(posedge pclk);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ***************************************************************
   // watchdog: the sequence needs about 300 cycles
   // ***************************************************************
   initial begin
      #50000;
      mismatches++;
      report_and_stop();
   end
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // reset values and an unmapped word
      rd_chk(`T2F_CTRL_OFF, {24'h000000, `T2F_CTRL_RST});
      rd_chk(`T2F_IRQ_STAT_OFF, 32'h0000_0000);
      rd_chk(`T2F_IRQ_MASK_OFF, 32'h0000_0000);
      rd_chk(`T2F_CFG_OFF, 32'h0000_0000);
      rd_chk(12'h010, 32'h0000_0000);
      check(32'(last_err), 32'h0000_0001);
      check(32'(pready), 32'h0000_0001);
      // let both status bits onto irq
      wr(`T2F_IRQ_MASK_OFF, 32'h0000_0003);
      rd_chk(`T2F_IRQ_MASK_OFF, 32'h0000_0003);
      // every select pair against both overflow sources
      for (int i = 3; i >= 0; i--) begin
         sel = 2'(i);
         wr(`T2F_CTRL_OFF, {26'h0, sel, 4'h0});
         for (int k = 0; k < 2; k++) begin
            r0 = rx_cnt;
            t0 = tx_cnt;
            ovf_pulse(k[0]);
            check(32'(rx_cnt - r0), 32'(sel[1] == k[0]));
            check(32'(tx_cnt - t0), 32'(sel[0] == k[0]));
         end
         check(32'(irq), 32'(i == 0));
         rd_chk(`T2F_IRQ_STAT_OFF, {30'h0, i == 0, 1'b0});
         rd_chk(`T2F_CTRL_OFF, {24'h0, i == 0, 1'b0, sel, 4'h0});
      end
      // flag survives time and a status read; only a write clears it
      repeat (20) @(posedge pclk);
      rd_chk(`T2F_CTRL_OFF, 32'h0000_0080);
      check(32'(irq), 32'h0000_0000);
      wr(`T2F_CTRL_OFF, 32'h0000_0000);
      rd_chk(`T2F_CTRL_OFF, 32'h0000_0000);
      // overflow on the setup edge of a status read waits for the next
      fork
         rd_chk(`T2F_IRQ_STAT_OFF, 32'h0000_0000);
         ovf_pulse(1'b1);
      join
      rd_chk(`T2F_IRQ_STAT_OFF, 32'h0000_0002);
      // serial port outside modes 1 and 3 takes no ticks
      serial_mode13 <= 1'b0;
      r0 = rx_cnt;
      t0 = tx_cnt;
      ovf_pulse(1'b0);
      check(32'(rx_cnt + tx_cnt - r0 - t0), 32'h0000_0000);
      serial_mode13 <= 1'b1;
      // trigger edge with enable: capture and flag, request gated by cfg
      wr(`T2F_CTRL_OFF, 32'h0000_0008);
      c0 = cap_cnt;
      trig_edge();
      check(32'(cap_cnt - c0), 32'h0000_0001);
      rd_chk(`T2F_CTRL_OFF, 32'h0000_0048);
      check(32'(t2_irq_req), 32'h0000_0000);
      check(32'(irq), 32'h0000_0001);
      wr(`T2F_CFG_OFF, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      check(32'(t2_irq_req), 32'h0000_0001);
      rd_chk(`T2F_IRQ_STAT_OFF, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      check(32'(irq), 32'h0000_0000);
      // masked event keeps irq low, status still records it
      wr(`T2F_IRQ_MASK_OFF, 32'h0000_0000);
      trig_edge();
      check(32'(irq), 32'h0000_0000);
      rd_chk(`T2F_IRQ_STAT_OFF, 32'h0000_0001);
      wr(`T2F_IRQ_MASK_OFF, 32'h0000_0003);
      wr(`T2F_CTRL_OFF, 32'h0000_0000);
      repeat (3) @(posedge pclk);
      check(32'(t2_irq_req), 32'h0000_0000);
      // enable clear: edge ignored
      c0 = cap_cnt;
      trig_edge();
      check(32'(cap_cnt - c0), 32'h0000_0000);
      rd_chk(`T2F_CTRL_OFF, 32'h0000_0000);
      // timer 2 clocking the receiver: no capture, no flag
      wr(`T2F_CTRL_OFF, 32'h0000_0028);
      c0 = cap_cnt;
      trig_edge();
      check(32'(cap_cnt - c0), 32'h0000_0000);
      rd_chk(`T2F_CTRL_OFF, 32'h0000_0028);
      report_and_stop();
   end
endmodule
